// *** common/tcm_pkg.sv ***
package tcm_pkg;
    // channels and widths
    localparam int TCM_NCH = 4;
    localparam int TCM_DW = 32;
    localparam int TCM_AW = 8;

    // register byte offsets
    localparam logic [7:0] TCM_OFS_CTRL = 8'h00;
    localparam logic [7:0] TCM_OFS_COUNT = 8'h04;
    localparam logic [7:0] TCM_OFS_PRLIM = 8'h08;
    localparam logic [7:0] TCM_OFS_PRCNT = 8'h0c;
    localparam logic [7:0] TCM_OFS_MCTRL = 8'h10;
    localparam logic [7:0] TCM_OFS_CCTRL = 8'h14;
    localparam logic [7:0] TCM_OFS_ECTRL = 8'h18;
    localparam logic [7:0] TCM_OFS_ESTATE = 8'h1c;
    localparam logic [7:0] TCM_OFS_MATCH = 8'h20;
    localparam logic [7:0] TCM_OFS_CAPT = 8'h30;
    localparam logic [7:0] TCM_OFS_STAT = 8'h40;
    localparam logic [7:0] TCM_OFS_MASK = 8'h44;

    // control register fields
    localparam int TCM_CTRL_EN = 0;
    localparam int TCM_CTRL_RST = 1;
    localparam int TCM_CTRL_MODE = 2;
    localparam int TCM_CTRL_ERISE = 3;
    localparam int TCM_CTRL_EFALL = 4;
    localparam int TCM_CTRL_W = 5;

    // per-channel field positions
    localparam int TCM_MC_RESET = 0;
    localparam int TCM_MC_STOP = 1;
    localparam int TCM_CC_RISE = 0;
    localparam int TCM_CC_FALL = 1;
    localparam int TCM_STAT_CAP = 4;

    // match output actions
    localparam logic [1:0] TCM_ACT_NONE = 2'h0;
    localparam logic [1:0] TCM_ACT_LOW = 2'h1;
    localparam logic [1:0] TCM_ACT_HIGH = 2'h2;
    localparam logic [1:0] TCM_ACT_TOGGLE = 2'h3;

    // reset values
    localparam logic [4:0] TCM_CTRL_RV = 5'h00;
    localparam logic [31:0] TCM_PRLIM_RV = 32'h0000_0000;
    localparam logic [31:0] TCM_MATCH_RV = 32'h0000_0000;
    localparam logic [7:0] TCM_MASK_RV = 8'h00;
endpackage

// *** core/tcm_edge_det.sv ***
`timescale 1ns/1ps
module tcm_edge_det
    import tcm_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sig_in,
    output logic rise_out,
    output logic fall_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } tcm_edge_s;

    tcm_edge_s r, n;

    always_comb begin
        n = r;
        n.s1 = sig_in;
        n.s2 = r.s1;
        n.prev = r.s2;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // edges seen only after two flops
    assign rise_out = r.s2 & ~r.prev;
    assign fall_out = ~r.s2 & r.prev;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_sync_rise_delay: assert property (rise_out
        |-> $past(sig_in, 2) && !$past(sig_in, 3))
        else $error("rise not two stages after pin");
    a_sync_fall_delay: assert property (fall_out
        |-> !$past(sig_in, 2) && $past(sig_in, 3))
        else $error("fall not two stages after pin");
endmodule // tcm_edge_det

// *** core/tcm_timer.sv ***
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Overview of operation
// - 32-bit counter advanced by a 32-bit programmable prescaler
// - timer mode counts clock cycles, counter mode counts external clock edges
// - four capture channels copy the counter on selected input transitions
// - capture sets a flag; interrupt only when its mask bit is set
// - four match registers flag equality, counter may keep running
// - a match may halt counter and prescaler
// - a match may reset counter to zero, giving a period
// - each match drives an output: low, high, toggle or unchanged
module tcm_timer
    import tcm_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [TCM_AW-1:0] paddr_in,
    input wire logic [TCM_DW-1:0] pwdata_in,
    output logic [TCM_DW-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic count_clk_in,
    input wire logic [TCM_NCH-1:0] capture_in,
    output logic [TCM_NCH-1:0] match_out,
    output logic irq_out
);
    typedef struct packed {
        logic [TCM_CTRL_W-1:0] ctrl;
        logic [31:0] tc;
        logic [31:0] pc;
        logic [31:0] pr;
        logic [2*TCM_NCH-1:0] mctrl;
        logic [2*TCM_NCH-1:0] cctrl;
        logic [2*TCM_NCH-1:0] ectrl;
        logic [TCM_NCH-1:0] ext;
        logic [TCM_NCH-1:0][31:0] match;
        logic [TCM_NCH-1:0][31:0] capt;
        logic [2*TCM_NCH-1:0] stat;
        logic [2*TCM_NCH-1:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } tcm_state_s;

    tcm_state_s r, n;

    logic [TCM_NCH:0] rise_w;
    logic [TCM_NCH:0] fall_w;
    logic [TCM_NCH:0] pins_w;
    logic cnt_ev;
    logic tick;
    logic run;
    logic roll;
    logic [TCM_NCH-1:0] hit;
    logic [TCM_NCH-1:0] hit_rst;
    logic [TCM_NCH-1:0] hit_stop;
    logic [TCM_NCH-1:0] cap_ev;
    logic wr;
    logic rd_setup;
    logic [1:0] idx;
    logic is_match;
    logic is_capt;

    // synchronisers: count input on slot TCM_NCH, captures below
    assign pins_w = {count_clk_in, capture_in};

    genvar g;
    generate
        for (g = 0; g <= TCM_NCH; g++) begin : g_sync
            tcm_edge_det u_edge (
                .core_clk_in(core_clk_in),
                .rst_in(rst_in),
                .sig_in(pins_w[g]),
                .rise_out(rise_w[g]),
                .fall_out(fall_w[g])
            );
        end
        for (g = 0; g < TCM_NCH; g++) begin : g_chan
            // match compare at prescaler rollover
            assign hit[g] = roll & (r.tc == r.match[g]);
            assign hit_rst[g] = hit[g] & r.mctrl[2*g+TCM_MC_RESET];
            assign hit_stop[g] = hit[g] & r.mctrl[2*g+TCM_MC_STOP];
            assign cap_ev[g] = (r.cctrl[2*g+TCM_CC_RISE] & rise_w[g]) |
                               (r.cctrl[2*g+TCM_CC_FALL] & fall_w[g]);
        end
    endgenerate

    // count event source
    assign cnt_ev = (r.ctrl[TCM_CTRL_ERISE] & rise_w[TCM_NCH]) |
                    (r.ctrl[TCM_CTRL_EFALL] & fall_w[TCM_NCH]);
    assign tick = r.ctrl[TCM_CTRL_MODE] ? cnt_ev : 1'b1;
    assign run = r.ctrl[TCM_CTRL_EN] & ~r.ctrl[TCM_CTRL_RST];
    assign roll = run & tick & (r.pc == r.pr);

    // apb decode
    assign wr = psel_in & penable_in & pwrite_in & r.pready;
    assign rd_setup = psel_in & penable_in & ~r.pready;
    assign idx = paddr_in[3:2];
    assign is_match = (paddr_in[7:4] == TCM_OFS_MATCH[7:4]) && (paddr_in[1:0] == 2'h0);
    assign is_capt = (paddr_in[7:4] == TCM_OFS_CAPT[7:4]) && (paddr_in[1:0] == 2'h0);

    always_comb begin
        n = r;

        // prescaler and counter
        if (r.ctrl[TCM_CTRL_RST]) begin
            n.tc = 32'h0000_0000;
            n.pc = 32'h0000_0000;
        end else if (run && tick) begin
            if (roll) begin
                n.pc = 32'h0000_0000;
                if (|hit_rst) begin
                    n.tc = 32'h0000_0000;
                end else if (|hit_stop) begin
                    n.tc = r.tc;
                end else begin
                    n.tc = r.tc + 32'h0000_0001;
                end
            end else begin
                n.pc = r.pc + 32'h0000_0001;
            end
        end

        // halt on match
        if (|hit_stop) begin
            n.ctrl[TCM_CTRL_EN] = 1'b0;
        end

        // match outputs and captures
        for (int i = 0; i < TCM_NCH; i++) begin
            if (hit[i]) begin
                case (r.ectrl[2*i +: 2])
                    TCM_ACT_LOW: n.ext[i] = 1'b0;
                    TCM_ACT_HIGH: n.ext[i] = 1'b1;
                    TCM_ACT_TOGGLE: n.ext[i] = ~r.ext[i];
                    default: n.ext[i] = r.ext[i];
                endcase
            end
            if (cap_ev[i]) begin
                n.capt[i] = r.tc;
            end
        end

        // apb read, one wait state
        n.pready = rd_setup;
        if (rd_setup) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h0000_0000;
            if (is_match) begin
                n.prdata = r.match[idx];
            end else if (is_capt) begin
                n.prdata = r.capt[idx];
            end else begin
                case (paddr_in)
                    TCM_OFS_CTRL: n.prdata[TCM_CTRL_W-1:0] = r.ctrl;
                    TCM_OFS_COUNT: n.prdata = r.tc;
                    TCM_OFS_PRLIM: n.prdata = r.pr;
                    TCM_OFS_PRCNT: n.prdata = r.pc;
                    TCM_OFS_MCTRL: n.prdata[2*TCM_NCH-1:0] = r.mctrl;
                    TCM_OFS_CCTRL: n.prdata[2*TCM_NCH-1:0] = r.cctrl;
                    TCM_OFS_ECTRL: n.prdata[2*TCM_NCH-1:0] = r.ectrl;
                    TCM_OFS_ESTATE: n.prdata[TCM_NCH-1:0] = r.ext;
                    TCM_OFS_STAT: n.prdata[2*TCM_NCH-1:0] = r.stat;
                    TCM_OFS_MASK: n.prdata[2*TCM_NCH-1:0] = r.mask;
                    default: n.pslverr = 1'b1;
                endcase
            end
        end else if (!psel_in) begin
            n.pslverr = 1'b0;
        end

        // apb write at the pready edge, software wins over counting
        if (wr && !r.pslverr) begin
            if (is_match) begin
                n.match[idx] = pwdata_in;
            end else begin
                case (paddr_in)
                    TCM_OFS_CTRL: n.ctrl = pwdata_in[TCM_CTRL_W-1:0];
                    TCM_OFS_COUNT: n.tc = pwdata_in;
                    TCM_OFS_PRLIM: n.pr = pwdata_in;
                    TCM_OFS_PRCNT: n.pc = pwdata_in;
                    TCM_OFS_MCTRL: n.mctrl = pwdata_in[2*TCM_NCH-1:0];
                    TCM_OFS_CCTRL: n.cctrl = pwdata_in[2*TCM_NCH-1:0];
                    TCM_OFS_ECTRL: n.ectrl = pwdata_in[2*TCM_NCH-1:0];
                    TCM_OFS_ESTATE: n.ext = pwdata_in[TCM_NCH-1:0];
                    TCM_OFS_MASK: n.mask = pwdata_in[2*TCM_NCH-1:0];
                    default: n.ctrl = n.ctrl;
                endcase
            end
        end

        // sticky flags: write one clears, new event wins
        n.stat = r.stat;
        if (wr && !r.pslverr && paddr_in == TCM_OFS_STAT) begin
            n.stat = r.stat & ~pwdata_in[2*TCM_NCH-1:0];
        end
        n.stat = n.stat | {cap_ev, hit};
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
            r.ctrl <= TCM_CTRL_RV;
            r.pr <= TCM_PRLIM_RV;
            r.mask <= TCM_MASK_RV;
            r.match <= {TCM_NCH{TCM_MATCH_RV}};
        end else begin
            r <= n;
        end
    end

    assign prdata_out = r.prdata;
    assign pready_out = r.pready;
    assign pslverr_out = r.pslverr;
    assign match_out = r.ext;
    assign irq_out = r.irq;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // prescaler and counter
    a_prescale_step: assert property (run && tick && !roll && !wr
        |=> r.pc == $past(r.pc) + 1)
        else $error("prescaler did not step");
    a_prescale_wrap: assert property (roll && !wr |=> r.pc == 32'h0)
        else $error("prescaler did not restart");
    a_timer_step: assert property (run && !r.ctrl[TCM_CTRL_MODE] && r.pr == 32'h0
        && r.pc == 32'h0 && !(|hit) && !wr |=> r.tc == $past(r.tc) + 1)
        else $error("limit zero did not advance every clock");
    a_count_inc: assert property (roll && !(|hit_rst) && !(|hit_stop) && !wr
        |=> r.tc == $past(r.tc) + 1)
        else $error("counter did not advance on rollover");
    a_hold_reset: assert property (r.ctrl[TCM_CTRL_RST] && !wr
        |=> r.tc == 32'h0 && r.pc == 32'h0)
        else $error("hold reset did not clear counter");
    a_counter_hold: assert property (r.ctrl[TCM_CTRL_MODE] && !cnt_ev && !wr
        && !r.ctrl[TCM_CTRL_RST] |=> r.tc == $past(r.tc) && r.pc == $past(r.pc))
        else $error("counter moved without an external edge");

    // captures and interrupt
    a_capture_copy: assert property (cap_ev[0] |=> r.capt[0] == $past(r.tc))
        else $error("capture did not copy counter");
    a_capture_hold: assert property (!cap_ev[2]
        |=> r.capt[2] == $past(r.capt[2]))
        else $error("capture register changed without event");
    a_capture_flag: assert property (cap_ev[1] |=> r.stat[TCM_STAT_CAP+1])
        else $error("capture flag not set");
    a_irq_gate: assert property (cap_ev[0] && r.mask[TCM_STAT_CAP] && !wr
        |=> irq_out)
        else $error("enabled capture raised no interrupt");
    a_irq_masked: assert property (r.mask == '0 && !wr
        |=> !irq_out)
        else $error("interrupt raised while all masked");

    // matches
    a_match_flag: assert property (hit[0] |=> r.stat[0])
        else $error("match flag not set");
    a_match_stop: assert property (hit_stop[0] && !(|hit_rst) && !wr
        |=> !r.ctrl[TCM_CTRL_EN] && r.tc == $past(r.tc) ##1 r.tc == $past(r.tc))
        else $error("counter not halted on match");
    a_stopped_hold: assert property (!r.ctrl[TCM_CTRL_EN] && !r.ctrl[TCM_CTRL_RST] && !wr
        |=> r.tc == $past(r.tc) && r.pc == $past(r.pc))
        else $error("stopped counter moved");
    a_match_reset: assert property (hit_rst[1] && !wr
        |=> r.tc == 32'h0 && r.pc == 32'h0)
        else $error("counter not reset on match");
    a_ext_toggle: assert property (hit[1] && r.ectrl[3:2] == TCM_ACT_TOGGLE && !wr
        |=> match_out[1] != $past(match_out[1]))
        else $error("match output did not toggle");
    a_ext_high: assert property (hit[0] && r.ectrl[1:0] == TCM_ACT_HIGH && !wr
        |=> match_out[0])
        else $error("match output not driven high");
    a_ext_low: assert property (hit[2] && r.ectrl[5:4] == TCM_ACT_LOW && !wr
        |=> !match_out[2])
        else $error("match output not driven low");
    a_ext_none: assert property (hit[3] && r.ectrl[7:6] == TCM_ACT_NONE && !wr
        |=> match_out[3] == $past(match_out[3]))
        else $error("match output changed on no action");
    a_ext_steady: assert property (!(|hit) && !wr
        |=> match_out == $past(match_out))
        else $error("match output changed without match");

    c_period: cover property (hit_rst[1] ##[1:50] hit_rst[1]);
    c_capture: cover property (cap_ev[0] ##1 irq_out);
    c_stop: cover property (hit_stop[0]);
    c_ext_count: cover property (r.ctrl[TCM_CTRL_MODE] && roll);
endmodule // tcm_timer

// *** sim/tcm_pins_model.sv ***
`timescale 1ns/1ps
module tcm_pins_model
    import tcm_pkg::*;
(
    input wire logic core_clk_in,
    output logic [TCM_NCH-1:0] capture_out,
    output logic count_clk_out
);
    initial begin
        capture_out = '0;
        count_clk_out = 1'b0;
    end
    // levels held two clocks each, so the sampler never misses an edge
    task automatic pulse_cap(input logic [TCM_NCH-1:0] m);
        capture_out <= m;
        repeat (2) @(posedge core_clk_in);
        capture_out <= '0;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic pulse_cnt(input int n);
        repeat (n) begin
            count_clk_out <= 1'b1;
            repeat (2) @(posedge core_clk_in);
            count_clk_out <= 1'b0;
            repeat (2) @(posedge core_clk_in);
        end
    endtask
endmodule // tcm_pins_model

// *** sim/timer_counter_capture_match_tb.sv ***
`timescale 1ns/1ps
module timer_counter_capture_match_tb;
    import tcm_pkg::*;
    localparam logic [1:0] ACTS [4] = '{TCM_ACT_HIGH, TCM_ACT_TOGGLE, TCM_ACT_LOW, TCM_ACT_NONE};
    logic clk, rst, psel, pen, pwr, pready, pslverr, cclk, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r, m, n, p, k;
    logic [3:0] cap, mo, es, ex;
    logic [31:0] seed = 32'd80469;
    int err_count, checks_done, iv;
    tcm_timer u_dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .count_clk_in(cclk),
        .capture_in(cap), .match_out(mo), .irq_out(irq));
    tcm_pins_model u_pins (.core_clk_in(clk), .capture_out(cap), .count_clk_out(cclk));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic act(input logic c, input logic [1:0] a);
        case (a)
            TCM_ACT_LOW: return 1'b0;
            TCM_ACT_HIGH: return 1'b1;
            TCM_ACT_TOGGLE: return ~c;
            default: return c;
        endcase
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50)
            chk(32'(pready), 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic wait_tog(output int c);
        logic o;
        o = mo[1];
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (mo[1] === o && c < 1000);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(TCM_OFS_CTRL, 32'(TCM_CTRL_RV));
        rdc(TCM_OFS_PRLIM, TCM_PRLIM_RV);
        rdc(TCM_OFS_MATCH, TCM_MATCH_RV);
        rdc(TCM_OFS_MASK, 32'(TCM_MASK_RV));
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, i ? 8'h05 : 8'h48, 32'h0);
            chk(32'(e), 32'h1);
            chk(q, 32'h0);
        end
        $display("test registers done");
        r = rnd();
        apb(1'b1, TCM_OFS_COUNT, r);
        apb(1'b1, TCM_OFS_CCTRL, 32'h39);
        u_pins.pulse_cap(4'hf);
        cyc(6);
        for (int i = 0; i < 4; i++)
            rdc(TCM_OFS_CAPT + 8'(4 * i), i == 3 ? 32'h0 : r);
        rdc(TCM_OFS_STAT, 32'h70);
        chk(32'(irq), 32'h0);
        apb(1'b1, TCM_OFS_MASK, 32'h70);
        cyc(2);
        chk(32'(irq), 32'h1);
        apb(1'b1, TCM_OFS_STAT, 32'h70);
        cyc(2);
        chk(32'(irq), 32'h0);
        u_pins.pulse_cap(4'h1);
        cyc(2);
        chk(32'(irq), 32'h1);
        rdc(TCM_OFS_STAT, 32'h10);
        apb(1'b1, TCM_OFS_STAT, 32'h70);
        cyc(2);
        $display("test capture done");
        n = rnd() % 4;
        m = 8 + rnd() % 13;
        es = 4'(rnd());
        k = 0;
        for (int i = 0; i < 4; i++) begin
            k |= 32'(ACTS[i]) << (2 * i);
            ex[i] = act(es[i], ACTS[i]);
            apb(1'b1, TCM_OFS_MATCH + 8'(4 * i), m);
        end
        apb(1'b1, TCM_OFS_COUNT, 32'h0);
        apb(1'b1, TCM_OFS_PRLIM, n);
        apb(1'b1, TCM_OFS_MCTRL, 32'h2);
        apb(1'b1, TCM_OFS_ECTRL, k);
        apb(1'b1, TCM_OFS_ESTATE, 32'(es));
        apb(1'b1, TCM_OFS_CTRL, 32'h1);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, TCM_OFS_CTRL, 32'h0);
            if (q[TCM_CTRL_EN] === 1'b0)
                break;
        end
        chk(32'(q[TCM_CTRL_EN]), 32'h0);
        rdc(TCM_OFS_COUNT, m);
        rdc(TCM_OFS_STAT, 32'h0f);
        chk(32'(mo), 32'(ex));
        rdc(TCM_OFS_ESTATE, 32'(ex));
        chk(32'(irq), 32'h0);
        apb(1'b1, TCM_OFS_MASK, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h1);
        apb(1'b1, TCM_OFS_STAT, 32'h0f);
        cyc(2);
        chk(32'(irq), 32'h0);
        $display("test stop done");
        p = 2 + rnd() % 4;
        apb(1'b1, TCM_OFS_MATCH + 8'h04, p);
        apb(1'b1, TCM_OFS_MCTRL, 32'h4);
        apb(1'b1, TCM_OFS_ECTRL, 32'hc);
        apb(1'b1, TCM_OFS_COUNT, 32'h0);
        apb(1'b1, TCM_OFS_CTRL, 32'h1);
        wait_tog(iv);
        wait_tog(iv);
        chk(32'(iv), (p + 1) * (n + 1));
        apb(1'b1, TCM_OFS_CTRL, 32'h0);
        $display("test period done");
        apb(1'b1, TCM_OFS_MCTRL, 32'h0);
        apb(1'b1, TCM_OFS_PRLIM, 32'h1);
        for (int j = 0; j < 2; j++) begin
            k = 4 + rnd() % 8;
            apb(1'b1, TCM_OFS_CTRL, 32'h2);
            apb(1'b1, TCM_OFS_CTRL, j ? 32'h15 : 32'h0d);
            u_pins.pulse_cnt(k);
            cyc(6);
            rdc(TCM_OFS_COUNT, k / 2);
            rdc(TCM_OFS_PRCNT, k % 2);
        end
        $display("test counter mode done");
        print_verdict();
    end
endmodule // timer_counter_capture_match_tb
